/* include/drt_pkg.sv */
// shared constants for the dual registered bus transceiver
package drt_pkg;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned LOG_DEPTH  = 8;

  // ----------------------------------------------------------------
  // variant selection
  // ----------------------------------------------------------------
  localparam bit ENABLE_SEPARATE = 1'b0;
  localparam bit ENABLE_SHARED   = 1'b1;
  localparam bit POLARITY_TRUE   = 1'b0;
  localparam bit POLARITY_INVERT = 1'b1;
  localparam bit OUTPUT_TRISTATE = 1'b0;
  localparam bit OUTPUT_OPEN_COL = 1'b1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_EDGE_PREV = 1'b0;
  localparam logic RST_OE        = 1'b0;
  localparam logic RST_DATA_BIT  = 1'b0;

endpackage : drt_pkg

/* logic/drt_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps

module drt_fifo #(
  parameter int unsigned WIDTH = drt_pkg::DATA_WIDTH,
  parameter int unsigned DEPTH = drt_pkg::LOG_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    fill;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_fill;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // pointer and level update
  // ----------------------------------------------------------------
  always_comb
  begin
    in_ready    = (fill != CW'(DEPTH));
    out_valid   = (fill != '0);
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
    end
    if (push && !pop)
    begin
      next_fill = fill + CW'(1);
    end
    else if (pop && !push)
    begin
      next_fill = fill - CW'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage needs no reset; out_data always shows mem[rd_ptr], but out_valid flags it only while the level is above zero
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];

endmodule : drt_fifo

/* logic/drt_transceiver.sv */
// dual registered eight-bit bus transceiver between an a port and a b port
// Summary of operation
// RULE1: moves words between a and b ports, one storage register per direction.
// RULE2: a port word can be captured and later driven onto b instead of live.
// RULE3: b port gets the same capture and stored-or-live transfer toward a.
// RULE4: shared variant drives a when enable low and direction low, b when high.
// RULE5: per-direction source select picks live opposite port or stored word.
// RULE6: each register loads from its port on its own capture clock rising edge.
// RULE7: capture happens regardless of enables, direction and select inputs.
// RULE8: separate variant: b driven while enable high, a while its enable low.
// RULE9: tying both separate enables together behaves like a direction input.
// RULE10: inverting or true polarity, three-state or open-collector outputs.
// RULE11: stored word holds until its next capture edge; undefined after power-up.
`timescale 1ns/1ps

module drt_transceiver #(
  parameter int unsigned WIDTH          = drt_pkg::DATA_WIDTH,
  parameter int unsigned LOG_DEPTH      = drt_pkg::LOG_DEPTH,
  parameter bit          SHARED_ENABLE  = drt_pkg::ENABLE_SEPARATE,
  parameter bit          INVERTING      = drt_pkg::POLARITY_TRUE,
  parameter bit          OPEN_COLLECTOR = drt_pkg::OUTPUT_TRISTATE
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // a port pins
  input  wire logic [WIDTH-1:0] a_in,
  output logic      [WIDTH-1:0] a_out,
  output logic      [WIDTH-1:0] a_oe,
  // b port pins
  input  wire logic [WIDTH-1:0] b_in,
  output logic      [WIDTH-1:0] b_out,
  output logic      [WIDTH-1:0] b_oe,
  // capture clocks, sampled as ordinary inputs
  input  wire logic             a_side_capture_clock,
  input  wire logic             b_side_capture_clock,
  // source selects
  input  wire logic             a_to_b_source_select,
  input  wire logic             b_to_a_source_select,
  // separate enable variant
  input  wire logic             b_output_drive_enable,
  input  wire logic             a_output_drive_enable_n,
  // shared enable variant
  input  wire logic             shared_enable_n,
  input  wire logic             direction,
  // log of captured a port words
  output logic      [WIDTH-1:0] log_data,
  output logic                  log_valid,
  input  wire logic             log_ready,
  output logic                  log_in_ready
);

  // ----------------------------------------------------------------
  // capture edge detection
  // ----------------------------------------------------------------
  logic             a_cap_prev;
  logic             b_cap_prev;
  logic             next_a_cap_prev;
  logic             next_b_cap_prev;
  logic             a_cap_rise;
  logic             b_cap_rise;

  // capture clocks are sampled: a pulse shorter than one period can be missed
  always_comb
  begin
    next_a_cap_prev = a_side_capture_clock;
    next_b_cap_prev = b_side_capture_clock;
    a_cap_rise      = a_side_capture_clock && !a_cap_prev;   // [RULE6]
    b_cap_rise      = b_side_capture_clock && !b_cap_prev;   // [RULE6]
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_cap_prev <= drt_pkg::RST_EDGE_PREV;
      b_cap_prev <= drt_pkg::RST_EDGE_PREV;
    end
    else
    begin
      a_cap_prev <= next_a_cap_prev;
      b_cap_prev <= next_b_cap_prev;
    end
  end

  // ----------------------------------------------------------------
  // storage registers
  // ----------------------------------------------------------------
  // no reset on purpose: contents are meaningless until first capture
  logic [WIDTH-1:0] ab_store;
  logic [WIDTH-1:0] ba_store;
  logic [WIDTH-1:0] next_ab_store;
  logic [WIDTH-1:0] next_ba_store;

  always_comb
  begin
    next_ab_store = ab_store;                          // [RULE11]
    next_ba_store = ba_store;                          // [RULE11]
    // enables, direction and selects deliberately play no part here
    if (a_cap_rise)
    begin
      next_ab_store = a_in;                            // [RULE2] [RULE6] [RULE7]
    end
    if (b_cap_rise)
    begin
      next_ba_store = b_in;                            // [RULE3] [RULE6] [RULE7]
    end
  end

  always_ff @(posedge ref_clk)
  begin
    ab_store <= next_ab_store;
    ba_store <= next_ba_store;
  end

  // ----------------------------------------------------------------
  // drive decision
  // ----------------------------------------------------------------
  logic             a_drive;
  logic             b_drive;

  always_comb
  begin
    if (SHARED_ENABLE)
    begin
      a_drive = !shared_enable_n && !direction;        // [RULE4]
      b_drive = !shared_enable_n && direction;         // [RULE4]
    end
    else
    begin
      // tied enables give exactly one driving port, high meaning b
      a_drive = !a_output_drive_enable_n;              // [RULE8] [RULE9]
      b_drive = b_output_drive_enable;                 // [RULE8] [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // b port output word and enables
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] b_word;
  logic [WIDTH-1:0] next_b_out;
  logic [WIDTH-1:0] next_b_oe;

  always_comb
  begin
    b_word = a_to_b_source_select ? ab_store : a_in;   // [RULE1] [RULE2] [RULE5]
    if (INVERTING)
    begin
      b_word = ~b_word;                                // [RULE10]
    end
    next_b_out = b_word;
    // open collector only pulls low; a high bit is left to the pull-up
    if (OPEN_COLLECTOR)
    begin
      next_b_oe = b_drive ? ~b_word : '0;              // [RULE10]
    end
    else
    begin
      next_b_oe = {WIDTH{b_drive}};                    // [RULE10]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      b_out <= {WIDTH{drt_pkg::RST_DATA_BIT}};
      b_oe  <= {WIDTH{drt_pkg::RST_OE}};
    end
    else
    begin
      b_out <= next_b_out;
      b_oe  <= next_b_oe;
    end
  end

  // ----------------------------------------------------------------
  // a port output word and enables
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] a_word;
  logic [WIDTH-1:0] next_a_out;
  logic [WIDTH-1:0] next_a_oe;

  always_comb
  begin
    a_word = b_to_a_source_select ? ba_store : b_in;   // [RULE1] [RULE3] [RULE5]
    if (INVERTING)
    begin
      a_word = ~a_word;                                // [RULE10]
    end
    next_a_out = a_word;
    // same pull-up reliance as the b port
    if (OPEN_COLLECTOR)
    begin
      next_a_oe = a_drive ? ~a_word : '0;              // [RULE10]
    end
    else
    begin
      next_a_oe = {WIDTH{a_drive}};                    // [RULE10]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      a_out <= {WIDTH{drt_pkg::RST_DATA_BIT}};
      a_oe  <= {WIDTH{drt_pkg::RST_OE}};
    end
    else
    begin
      a_out <= next_a_out;
      a_oe  <= next_a_oe;
    end
  end

  // ----------------------------------------------------------------
  // capture log
  // ----------------------------------------------------------------
  // a full log drops the entry but never blocks the register capture
  drt_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (a_in),
    .in_valid  (a_cap_rise),
    .in_ready  (log_in_ready),
    .out_data  (log_data),
    .out_valid (log_valid),
    .out_ready (log_ready)
  );

endmodule : drt_transceiver

/* verification/drt_transceiver_properties.sv */
// port-level assertion checker for the dual registered transceiver
`timescale 1ns/1ps

module drt_transceiver_checker #(
  parameter int unsigned WIDTH  = 8,
  parameter bit          SHARED = 1'b0,
  parameter bit          INV    = 1'b0,
  parameter bit          OC     = 1'b0
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             sys_rst,
  // port pins
  input wire logic [WIDTH-1:0] a_in,
  input wire logic [WIDTH-1:0] b_in,
  input wire logic [WIDTH-1:0] a_out,
  input wire logic [WIDTH-1:0] b_out,
  input wire logic [WIDTH-1:0] a_oe,
  input wire logic [WIDTH-1:0] b_oe,
  // controls
  input wire logic             a_side_capture_clock,
  input wire logic             b_side_capture_clock,
  input wire logic             a_to_b_source_select,
  input wire logic             b_to_a_source_select,
  input wire logic             b_output_drive_enable,
  input wire logic             a_output_drive_enable_n,
  // log
  input wire logic [WIDTH-1:0] log_data,
  input wire logic             log_valid,
  input wire logic             log_in_ready
);
  default clocking cb @(posedge ref_clk);
  endclocking
  // these properties describe the separate, true, three-state variant only
  localparam bit PLAIN = !SHARED && !INV && !OC;
  default disable iff (sys_rst || !PLAIN);

  sequence s_cap_a;
    $rose(a_side_capture_clock) ##1 (a_to_b_source_select && b_output_drive_enable);
  endsequence
  sequence s_cap_b;
    $rose(b_side_capture_clock) ##1 (b_to_a_source_select && !a_output_drive_enable_n);
  endsequence

  property p_oe_b;
    !$past(sys_rst) |-> b_oe == {WIDTH{$past(b_output_drive_enable)}};
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("b enable wrong");
  property p_oe_a;
    !$past(sys_rst) |-> a_oe == {WIDTH{!$past(a_output_drive_enable_n)}};
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("a enable wrong");
  property p_live_b;
    !$past(sys_rst) && $past(b_output_drive_enable) && !$past(a_to_b_source_select) |-> b_out == $past(a_in);
  endproperty
  a_live_b: assert property (p_live_b) else $error("live a word not on b");
  property p_live_a;
    !$past(sys_rst) && !$past(a_output_drive_enable_n) && !$past(b_to_a_source_select) |-> a_out == $past(b_in);
  endproperty
  a_live_a: assert property (p_live_a) else $error("live b word not on a");
  property p_store_a;
    s_cap_a |=> b_out == $past(a_in, 2);
  endproperty
  a_store_a: assert property (p_store_a) else $error("stored a word not on b");
  property p_store_b;
    s_cap_b |=> a_out == $past(b_in, 2);
  endproperty
  a_store_b: assert property (p_store_b) else $error("stored b word not on a");
  property p_hold_a;
    (a_to_b_source_select && b_output_drive_enable && !$rose(a_side_capture_clock) && !$past(sys_rst))
      ##1 (a_to_b_source_select && b_output_drive_enable) |=> $stable(b_out);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("stored word changed");
  property p_log_push;
    $rose(a_side_capture_clock) && log_in_ready && !log_valid |=> log_valid && log_data == $past(a_in);
  endproperty
  a_log_push: assert property (p_log_push) else $error("captured word not logged");
endmodule : drt_transceiver_checker

bind drt_transceiver drt_transceiver_checker #(.WIDTH(WIDTH), .SHARED(SHARED_ENABLE), .INV(INVERTING),
  .OC(OPEN_COLLECTOR)) u_chk (.ref_clk, .sys_rst, .a_in, .b_in, .a_out,
  .b_out, .a_oe, .b_oe, .a_side_capture_clock, .b_side_capture_clock, .a_to_b_source_select,
  .b_to_a_source_select, .b_output_drive_enable, .a_output_drive_enable_n, .log_data, .log_valid, .log_in_ready);

/* verification/drt_bus_partner.sv */
// far side bus logic on the a and b ports
`timescale 1ns/1ps

module drt_bus_partner (
  // design side
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  // far side words
  input  wire logic [7:0] a_drv,
  input  wire logic [7:0] b_drv,
  // resolved pin levels
  output logic      [7:0] a_in,
  output logic      [7:0] b_in
);
  // far side backs off bit by bit wherever the block drives
  assign a_in = (a_oe & a_out) | (~a_oe & a_drv);
  assign b_in = (b_oe & b_out) | (~b_oe & b_drv);
endmodule : drt_bus_partner

/* verification/drt_transceiver_bench.sv */
// self-checking bench for the dual registered transceiver
`timescale 1ns/1ps

module drt_transceiver_bench;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] a_in, b_in, a_out, b_out, a_oe, b_oe, log_data;
  logic [7:0] a_drv = 8'h00;
  logic [7:0] b_drv = 8'h00;
  logic       a_side_capture_clock = 1'b0, b_side_capture_clock = 1'b0;
  logic       a_to_b_source_select = 1'b0, b_to_a_source_select = 1'b0;
  logic       b_output_drive_enable = 1'b0, a_output_drive_enable_n = 1'b1;
  logic       log_ready = 1'b0, log_valid, log_in_ready;
  logic       shared_en_n = 1'b1, dir = 1'b0;
  logic [7:0] s_a_out, s_a_oe, s_b_out, s_b_oe;
  int         n_errors = 0;
  int         total_checks = 0;

  drt_transceiver uut (.ref_clk, .sys_rst, .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe,
    .a_side_capture_clock, .b_side_capture_clock, .a_to_b_source_select, .b_to_a_source_select,
    .b_output_drive_enable, .a_output_drive_enable_n, .shared_enable_n(1'b1), .direction(1'b0),
    .log_data, .log_valid, .log_ready, .log_in_ready);
  drt_bus_partner far_side (.a_out, .a_oe, .b_out, .b_oe, .a_drv, .b_drv, .a_in, .b_in);
  // second variant: shared enable, inverting, open collector, far side drives directly
  drt_transceiver #(.SHARED_ENABLE(drt_pkg::ENABLE_SHARED), .INVERTING(drt_pkg::POLARITY_INVERT),
    .OPEN_COLLECTOR(drt_pkg::OUTPUT_OPEN_COL)) uut_shared (.ref_clk, .sys_rst, .a_in(a_drv),
    .a_out(s_a_out), .a_oe(s_a_oe), .b_in(b_drv), .b_out(s_b_out), .b_oe(s_b_oe),
    .a_side_capture_clock, .b_side_capture_clock, .a_to_b_source_select, .b_to_a_source_select,
    .b_output_drive_enable, .a_output_drive_enable_n, .shared_enable_n(shared_en_n), .direction(dir),
    .log_data(), .log_valid(), .log_ready(1'b0), .log_in_ready());

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic set_en(input logic eb, input logic ea_n);
    b_output_drive_enable = eb;
    a_output_drive_enable_n = ea_n;
  endtask : set_en

  // both far sides offer the word; only one capture clock pulses
  task automatic cap(input logic side_b, input logic [7:0] w);
    a_drv = w;
    b_drv = w;
    a_side_capture_clock = !side_b;
    b_side_capture_clock = side_b;
    cyc(1);
    a_side_capture_clock = 1'b0;
    b_side_capture_clock = 1'b0;
    cyc(1);
  endtask : cap

  task automatic t_live;
    set_en(1'b1, 1'b1);
    a_drv = 8'h5A;
    cyc(2);
    chk("b_out", 8'h5A, b_out);
    chk("b_oe", 8'hFF, b_oe);
    chk("a_oe", 8'h00, a_oe);
    set_en(1'b0, 1'b0);
    b_drv = 8'hC3;
    cyc(2);
    chk("a_out", 8'hC3, a_out);
    chk("b_oe", 8'h00, b_oe);
  endtask : t_live

  task automatic t_tied;
    for (int t = 0; t < 2; t++)
    begin
      set_en(t[0], t[0]);
      cyc(2);
      chk("b_oe", {8{t[0]}}, b_oe);
      chk("a_oe", {8{!t[0]}}, a_oe);
    end
  endtask : t_tied

  // capture with outputs off, then show the stored word over a new live one
  task automatic t_store;
    set_en(1'b0, 1'b1);
    cap(1'b0, 8'h33);
    cap(1'b1, 8'h6C);
    a_drv = 8'h44;
    b_drv = 8'h11;
    a_to_b_source_select = 1'b1;
    set_en(1'b1, 1'b1);
    cyc(2);
    chk("b_out", 8'h33, b_out);
    cyc(6);
    chk("b_out", 8'h33, b_out);
    chk("log_data", 8'h33, log_data);
    log_ready = 1'b1;
    cyc(1);
    log_ready = 1'b0;
    chk("log_valid", 8'h00, log_valid);
    a_to_b_source_select = 1'b0;
    b_to_a_source_select = 1'b1;
    set_en(1'b0, 1'b0);
    cyc(2);
    chk("a_out", 8'h6C, a_out);
    b_to_a_source_select = 1'b0;
  endtask : t_store

  // log takes eight words, drops the ninth, drains in order
  task automatic t_fill;
    set_en(1'b0, 1'b1);
    // let the a port enable fall before the far side offers words
    cyc(2);
    for (int i = 1; i <= 9; i++)
      cap(1'b0, 8'(i));
    chk("log_in_ready", 8'h00, log_in_ready);
    log_ready = 1'b1;
    for (int i = 1; i <= 8; i++)
    begin
      chk("log_data", 8'(i), log_data);
      cyc(1);
    end
    log_ready = 1'b0;
    chk("log_valid", 8'h00, log_valid);
  endtask : t_fill

  // register loaded while log was full; new captures shown the cycle after
  task automatic t_recap;
    a_to_b_source_select = 1'b1;
    set_en(1'b1, 1'b1);
    cyc(2);
    chk("b_out", 8'h09, b_out);
    cap(1'b0, 8'hA7);
    chk("b_out", 8'hA7, b_out);
    b_to_a_source_select = 1'b1;
    set_en(1'b0, 1'b0);
    cyc(2);
    cap(1'b1, 8'h9E);
    chk("a_out", 8'h9E, a_out);
    a_to_b_source_select = 1'b0;
    b_to_a_source_select = 1'b0;
  endtask : t_recap

  // shared enable with direction, inverted words, open collector enables
  task automatic t_shared;
    a_drv = 8'h5A;
    b_drv = 8'h3C;
    shared_en_n = 1'b0;
    dir = 1'b0;
    cyc(2);
    chk("s_a_out", 8'hC3, s_a_out);
    chk("s_a_oe", 8'h3C, s_a_oe);
    chk("s_b_oe", 8'h00, s_b_oe);
    dir = 1'b1;
    cyc(2);
    chk("s_b_out", 8'hA5, s_b_out);
    chk("s_b_oe", 8'h5A, s_b_oe);
    chk("s_a_oe", 8'h00, s_a_oe);
    shared_en_n = 1'b1;
    cyc(2);
    chk("s_b_oe", 8'h00, s_b_oe);
  endtask : t_shared

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    cyc(1);
    sys_rst = 1'b0;
    cyc(1);
    t_live();
    t_tied();
    t_store();
    t_fill();
    t_recap();
    t_shared();
    report_and_stop();
  end
endmodule : drt_transceiver_bench
